// *** ppfs_pkg.sv ***
package ppfs_pkg;

  // Pin counts per port section
  localparam int P1_PINS    = 8;
  localparam int P3_PINS    = 5;
  localparam int P4_PINS    = 8;
  localparam int MAP_W      = 5;
  localparam int CHAN_SEL_W = 4;

  // Pin positions inside port one
  localparam int P1_AUXCLK_PIN = 0;
  localparam int P1_CMP_PIN    = 6;
  // Shared serial-clock pin inside port three
  localparam int P3_BCLK_PIN   = 2;

  // Largest legal port-four mapping value
  localparam logic [4:0] MAP_MAX = 5'h1e;

  // Converter channels wired to the reference pins
  localparam logic [3:0] CH_POS_REF = 4'h8;
  localparam logic [3:0] CH_NEG_REF = 4'h9;

  // Reset values of the registered controls
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;

  // Per-pin pad drive bundle: output value, output enable, input buffer on
  typedef struct packed {
    logic out;
    logic oe;
    logic ie;
  } ppfs_pad_t;

  // Serial-interface pin request: out value, drive enable, open-drain flag
  typedef struct packed {
    logic out;
    logic oe;
    logic od;
  } ppfs_per_t;

endpackage : ppfs_pkg

// *** ppfs_port_pin_function_select.sv ***
// Contract
// - Port one select/direction choose GPIO or timer (aux clock on pin0, comparator on pin6)
// - Port-two pin7 serial function, peripheral sets direction
// - Serial-a clock beats serial-b enable, forces 3-wire
// - Port-three pins 0-4 serial, peripheral sets direction
// - I2C mode drives low only
// - Serial-b clock beats serial-a enable, forces 3-wire
// - Port four mapping at most 30 selects function
// - Some mapped functions set their own direction
// - Port five pins 0/1 analog: buffers off
// - Reference enable chooses output or external input
// - Channels eight/nine connect to reference pins
// - Port five pin2 select: crystal or bypass input
// - Pin3 follows pin2 select; bypass keeps GPIO
module ppfs_port_pin_function_select
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  // Port one controls and timer side
  input  wire logic [7:0]                 port_one_function_select_i,
  input  wire logic [7:0]                 port_one_direction_bit_i,
  input  wire logic [7:0]                 port_one_gpio_out_i,
  input  wire logic [7:0]                 port_one_timer_out_i,
  input  wire logic                       aux_clock_i,
  input  wire logic                       comparator_output_i,
  // Port two pin seven controls
  input  wire logic                       port_two_function_select_i,
  input  wire logic                       port_two_direction_bit_i,
  input  wire logic                       port_two_gpio_out_i,
  // Port three controls
  input  wire logic [4:0]                 port_three_function_select_i,
  input  wire logic [4:0]                 port_three_direction_bit_i,
  input  wire logic [4:0]                 port_three_gpio_out_i,
  // Serial interface requests
  input  wire ppfs_pkg::ppfs_per_t [4:0]  serial_pin_req_i,
  input  wire ppfs_pkg::ppfs_per_t        serial_a_clock_req_i,
  input  wire logic                       serial_four_wire_i,
  // Port four controls and mapped functions
  input  wire logic [7:0]                 port_four_function_select_i,
  input  wire logic [7:0]                 port_four_direction_bit_i,
  input  wire logic [7:0]                 port_four_gpio_out_i,
  input  wire logic [39:0]                port_four_mapping_value_i,
  input  wire logic [7:0]                 mapped_out_i,
  input  wire logic [7:0]                 mapped_dir_own_i,
  input  wire logic [7:0]                 mapped_dir_i,
  // Port five controls
  input  wire logic [3:0]                 port_five_select_i,
  input  wire logic [3:0]                 port_five_direction_bit_i,
  input  wire logic [3:0]                 port_five_gpio_out_i,
  input  wire logic                       reference_output_enable_i,
  input  wire logic                       hf_oscillator_bypass_i,
  input  wire logic [3:0]                 converter_channel_select_i,
  // Pad inputs from pins
  input  wire logic [7:0]                 p1_pad_i,
  input  wire logic                       p2_pad_i,
  input  wire logic [4:0]                 p3_pad_i,
  input  wire logic [7:0]                 p4_pad_i,
  input  wire logic [3:0]                 p5_pad_i,
  // Pad drives
  output ppfs_pkg::ppfs_pad_t [7:0]       p1_pad_o,
  output ppfs_pkg::ppfs_pad_t             p2_pad_o,
  output ppfs_pkg::ppfs_pad_t [4:0]       p3_pad_o,
  output ppfs_pkg::ppfs_pad_t [7:0]       p4_pad_o,
  output ppfs_pkg::ppfs_pad_t [3:0]       p5_pad_o,
  // Peripheral-side inputs and status
  output logic [7:0]                      timer_capture_o,
  output logic [4:0]                      serial_pin_in_o,
  output logic                            serial_a_clock_in_o,
  output logic                            serial_three_wire_o,
  output logic [7:0]                      mapped_in_o,
  output logic [7:0]                      port_one_pin_in_o,
  output logic                            ref_pos_out_en_o,
  output logic                            ext_ref_in_en_o,
  output logic                            chan_to_pos_ref_o,
  output logic                            chan_to_neg_ref_o,
  output logic                            hf_crystal_input_en_o,
  output logic                            hf_bypass_in_en_o,
  output logic                            hf_crystal_output_en_o,
  output logic                            hf_clock_in_o
);

  // Synchronised pad inputs (two stages, second stage alone is read)
  logic [31:0] pad_s1_r;
  logic [31:0] pad_s2_r;
  wire  [31:0] pad_raw = {p5_pad_i, p4_pad_i, p3_pad_i, p2_pad_i, 6'h00, p1_pad_i};
  wire  [7:0]  p1_s    = pad_s2_r[7:0];
  wire         p2_s    = pad_s2_r[14];
  wire  [4:0]  p3_s    = pad_s2_r[19:15];
  wire  [7:0]  p4_s    = pad_s2_r[27:20];
  wire  [3:0]  p5_s    = pad_s2_r[31:28];

  // Pad input synchroniser
  always_ff @(posedge clk_i)
  begin
    pad_s1_r <= pad_raw;
    pad_s2_r <= pad_s1_r;
  end

  // Package pin counts must agree with the fixed port widths
  if (ppfs_pkg::P1_PINS != $bits(port_one_function_select_i) ||
      ppfs_pkg::P3_PINS != $bits(port_three_function_select_i) ||
      ppfs_pkg::P4_PINS != $bits(port_four_function_select_i) ||
      ppfs_pkg::MAP_W * ppfs_pkg::P4_PINS != $bits(port_four_mapping_value_i) ||
      ppfs_pkg::CHAN_SEL_W != $bits(converter_channel_select_i))
  begin : g_size_chk
    $error("package pin counts do not match the port widths");
  end

  // Legal mapping value of a port-four pin
  function automatic logic map_ok(input logic [4:0] v);
    map_ok = (v <= ppfs_pkg::MAP_MAX);
  endfunction : map_ok

  // Open-drain conversion for a serial request
  function automatic ppfs_pkg::ppfs_pad_t per_pad(input ppfs_pkg::ppfs_per_t r);
    per_pad.ie  = 1'b1;
    per_pad.out = r.od ? 1'b0 : r.out;
    per_pad.oe  = r.od ? (r.oe & ~r.out) : r.oe;
  endfunction : per_pad

  // Port one pad decode
  ppfs_pkg::ppfs_pad_t [7:0] p1_nxt;
  logic [7:0]                p1_val;
  generate
    for (genvar i = 0; i < ppfs_pkg::P1_PINS; i++)
    begin : g_p1
      assign p1_val[i] = !port_one_function_select_i[i] ? port_one_gpio_out_i[i] :
                         (i == ppfs_pkg::P1_AUXCLK_PIN) ? aux_clock_i :
                         (i == ppfs_pkg::P1_CMP_PIN) ? comparator_output_i :
                         port_one_timer_out_i[i];
      assign p1_nxt[i] = '{out: p1_val[i], oe: port_one_direction_bit_i[i], ie: 1'b1};
    end
  endgenerate

  // Shared serial pins with priority of clock over slave enable
  wire three_wire_nxt = serial_four_wire_i &
                        (port_two_function_select_i | port_three_function_select_i[2]);
  ppfs_pkg::ppfs_pad_t p2_nxt;
  ppfs_pkg::ppfs_pad_t p2_gpio;
  assign p2_gpio = '{out: port_two_gpio_out_i, oe: port_two_direction_bit_i, ie: 1'b1};
  assign p2_nxt  = port_two_function_select_i ? per_pad(serial_a_clock_req_i) :
                   p2_gpio;

  // Port three pad decode
  ppfs_pkg::ppfs_pad_t [4:0] p3_nxt;
  generate
    for (genvar i = 0; i < ppfs_pkg::P3_PINS; i++)
    begin : g_p3
      ppfs_pkg::ppfs_pad_t gpio_pad;
      assign gpio_pad  = '{out: port_three_gpio_out_i[i], oe: port_three_direction_bit_i[i],
                           ie: 1'b1};
      assign p3_nxt[i] = port_three_function_select_i[i] ? per_pad(serial_pin_req_i[i]) :
                         gpio_pad;
    end
  endgenerate

  // Port four pad decode
  ppfs_pkg::ppfs_pad_t [7:0] p4_nxt;
  logic [7:0]                p4_alt;
  generate
    for (genvar i = 0; i < ppfs_pkg::P4_PINS; i++)
    begin : g_p4
      wire [ppfs_pkg::MAP_W-1:0] map_v;
      assign map_v     = port_four_mapping_value_i[i*ppfs_pkg::MAP_W +: ppfs_pkg::MAP_W];
      assign p4_alt[i] = port_four_function_select_i[i] & map_ok(map_v);
      assign p4_nxt[i].out = p4_alt[i] ? mapped_out_i[i] : port_four_gpio_out_i[i];
      assign p4_nxt[i].oe  = (p4_alt[i] & mapped_dir_own_i[i]) ? mapped_dir_i[i] :
                             port_four_direction_bit_i[i];
      assign p4_nxt[i].ie  = 1'b1;
    end
  endgenerate

  // Port five pad decode
  ppfs_pkg::ppfs_pad_t [3:0] p5_nxt;
  wire p52_sel = port_five_select_i[2];
  wire xtal    = p52_sel & ~hf_oscillator_bypass_i;

  // GPIO view of each port-five pin, and a pad with both buffers off
  localparam ppfs_pkg::ppfs_pad_t PAD_OFF = '{out: 1'b0, oe: 1'b0, ie: 1'b0};
  ppfs_pkg::ppfs_pad_t [3:0] p5_gpio;
  ppfs_pkg::ppfs_pad_t       p5_osc;
  generate
    for (genvar i = 0; i < $bits(port_five_select_i); i++)
    begin : g_p5g
      assign p5_gpio[i] = '{out: port_five_gpio_out_i[i], oe: port_five_direction_bit_i[i],
                            ie: 1'b1};
    end
    for (genvar i = 0; i < 2; i++)
    begin : g_p5a
      assign p5_nxt[i] = port_five_select_i[i] ? PAD_OFF : p5_gpio[i];
    end
  endgenerate

  // Oscillator pin pair: input buffer only in bypass mode
  assign p5_osc    = '{out: 1'b0, oe: 1'b0, ie: hf_oscillator_bypass_i};
  assign p5_nxt[2] = p52_sel ? p5_osc : p5_gpio[2];
  assign p5_nxt[3] = xtal ? PAD_OFF : p5_gpio[3];

  // Analog and oscillator steering
  wire any_ref   = port_five_select_i[0];
  wire refo_nxt  = any_ref & reference_output_enable_i;
  wire eref_nxt  = any_ref & ~reference_output_enable_i;
  wire ch8_nxt   = port_five_select_i[0] & (converter_channel_select_i == ppfs_pkg::CH_POS_REF);
  wire ch9_nxt   = port_five_select_i[1] & (converter_channel_select_i == ppfs_pkg::CH_NEG_REF);

  // Peripheral-side inputs gated by their selects; port-one GPIO readback never masked
  logic [7:0] cap_nxt;
  logic [7:0] min_nxt;
  generate
    for (genvar i = 0; i < ppfs_pkg::P1_PINS; i++)
    begin : g_in
      assign cap_nxt[i] = port_one_function_select_i[i] & ~port_one_direction_bit_i[i] & p1_s[i];
      assign min_nxt[i] = p4_alt[i] & p4_s[i];
    end
  endgenerate

  // Output registers; selects and directions act one edge later
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      p1_pad_o               <= '{default: '0};
      p2_pad_o               <= '0;
      p3_pad_o               <= '{default: '0};
      p4_pad_o               <= '{default: '0};
      p5_pad_o               <= '{default: '0};
      timer_capture_o        <= ppfs_pkg::SEL_RST;
      serial_pin_in_o        <= '0;
      serial_a_clock_in_o    <= 1'b0;
      serial_three_wire_o    <= 1'b0;
      mapped_in_o            <= ppfs_pkg::SEL_RST;
      port_one_pin_in_o      <= ppfs_pkg::DIR_RST;
      ref_pos_out_en_o       <= 1'b0;
      ext_ref_in_en_o        <= 1'b0;
      chan_to_pos_ref_o      <= 1'b0;
      chan_to_neg_ref_o      <= 1'b0;
      hf_crystal_input_en_o  <= 1'b0;
      hf_bypass_in_en_o      <= 1'b0;
      hf_crystal_output_en_o <= 1'b0;
      hf_clock_in_o          <= 1'b0;
    end
    else
    begin
      p1_pad_o               <= p1_nxt;
      p2_pad_o               <= p2_nxt;
      p3_pad_o               <= p3_nxt;
      p4_pad_o               <= p4_nxt;
      p5_pad_o               <= p5_nxt;
      timer_capture_o        <= cap_nxt;
      serial_pin_in_o        <= p3_s & port_three_function_select_i;
      serial_a_clock_in_o    <= p2_s & port_two_function_select_i;
      serial_three_wire_o    <= three_wire_nxt;
      mapped_in_o            <= min_nxt;
      port_one_pin_in_o      <= p1_s;
      ref_pos_out_en_o       <= refo_nxt;
      ext_ref_in_en_o        <= eref_nxt;
      chan_to_pos_ref_o      <= ch8_nxt;
      chan_to_neg_ref_o      <= ch9_nxt;
      hf_crystal_input_en_o  <= xtal;
      hf_bypass_in_en_o      <= p52_sel & hf_oscillator_bypass_i;
      hf_crystal_output_en_o <= xtal;
      hf_clock_in_o          <= p52_sel & hf_oscillator_bypass_i & p5_s[2];
    end
  end

  // Checks
  property p_reset_clear;
    @(posedge clk_i) !reset_n_i |=> (p1_pad_o[0].oe == 1'b0 && p5_pad_o[0].ie == 1'b0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("pads not cleared at reset");

  property p_p1_dir;
    @(posedge clk_i) disable iff (!reset_n_i)
      1'b1 |=> p1_pad_o[1].oe == $past(port_one_direction_bit_i[1]);
  endproperty
  a_p1_dir: assert property (p_p1_dir) else $error("port one direction wrong");

  property p_p2_dir;
    @(posedge clk_i) disable iff (!reset_n_i)
      port_two_function_select_i && !serial_a_clock_req_i.od |=>
      p2_pad_o.oe == $past(serial_a_clock_req_i.oe);
  endproperty
  a_p2_dir: assert property (p_p2_dir) else $error("shared pin direction wrong");

  property p_three_wire;
    @(posedge clk_i) disable iff (!reset_n_i)
      serial_four_wire_i && port_two_function_select_i |=> serial_three_wire_o;
  endproperty
  a_three_wire: assert property (p_three_wire) else $error("not forced to three wire");

  property p_od;
    @(posedge clk_i) disable iff (!reset_n_i)
      port_three_function_select_i[0] && serial_pin_req_i[0].od |=> p3_pad_o[0].out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("open-drain drove high");

  property p_map;
    @(posedge clk_i) disable iff (!reset_n_i)
      port_four_mapping_value_i[ppfs_pkg::MAP_W +: ppfs_pkg::MAP_W] > ppfs_pkg::MAP_MAX |=>
      p4_pad_o[1].out == $past(port_four_gpio_out_i[1]) &&
      p4_pad_o[1].oe == $past(port_four_direction_bit_i[1]);
  endproperty
  a_map: assert property (p_map) else $error("illegal mapping used");

  property p_analog;
    @(posedge clk_i) disable iff (!reset_n_i)
      port_five_select_i[1] |=> !p5_pad_o[1].oe && !p5_pad_o[1].ie;
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin buffers on");

  property p_xtal;
    @(posedge clk_i) disable iff (!reset_n_i)
      port_five_select_i[2] && hf_oscillator_bypass_i |=>
      !hf_crystal_output_en_o && p5_pad_o[3].oe == $past(port_five_direction_bit_i[3]);
  endproperty
  a_xtal: assert property (p_xtal) else $error("bypass pin three not GPIO");

endmodule : ppfs_port_pin_function_select

// *** ppfs_periph_model.sv ***
module ppfs_periph_model
(
  // Bench-chosen serial mode
  input  wire logic                  i2c_mode_i,
  // Peripheral drives toward the pin mux
  output logic [7:0]                 timer_out_o,
  output logic                       aux_clock_o,
  output logic                       cmp_out_o,
  output ppfs_pkg::ppfs_per_t [4:0]  ser_req_o,
  output ppfs_pkg::ppfs_per_t        ser_a_req_o,
  output logic [7:0]                 map_out_o,
  output logic [7:0]                 map_own_o,
  output logic [7:0]                 map_dir_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Distinct patterns so every source but the aux clock (same as timer bit0) can be told apart at the pins
  assign timer_out_o = 8'ha5;
  assign aux_clock_o = 1'b1;
  assign cmp_out_o   = 1'b1;
  assign ser_a_req_o = 3'h6;
  assign map_out_o   = 8'h3c;
  assign map_own_o   = 8'h0f;
  assign map_dir_o   = 8'h33;

  // Serial data alternates per pin; I2C mode asks for open drain
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      ser_req_o[i] = {i[0], 1'b1, i2c_mode_i};
    end
  end
endmodule : ppfs_periph_model

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MAX_CYC = 2000;
  // Bench-driven controls and pin levels
  logic                      clk_i, reset_n_i, s2, d2, g2, pd2, fw, rfo, byp, i2c;
  logic [7:0]                s1, d1, g1, pd1, s4, d4, g4, pd4;
  logic [4:0]                s3, d3, g3, pd3;
  logic [3:0]                s5, d5, g5, pd5, ch;
  logic [39:0]               mv;
  // Partner drives
  logic [7:0]                tmo, mo, mown, mdir;
  logic                      aux, cmp;
  ppfs_pkg::ppfs_per_t [4:0] sreq;
  ppfs_pkg::ppfs_per_t       sareq;
  // Design outputs
  ppfs_pkg::ppfs_pad_t [7:0] o1, o4;
  ppfs_pkg::ppfs_pad_t [4:0] o3n;
  ppfs_pkg::ppfs_pad_t [3:0] o5n;
  ppfs_pkg::ppfs_pad_t       o2n;
  logic [23:0]               o2, o3, o5;
  logic [7:0]                cap, mi, pin1;
  logic [4:0]                sin;
  logic                      sain, tw, rpos, xref, cpos, cneg, xin, bin, xout, hclk;
  int                        num_errors, compares, cyc;

  // Narrow pad groups padded to eight pads for fld
  assign o2 = {21'h00_0000, o2n};
  assign o3 = {9'h000, o3n};
  assign o5 = {12'h000, o5n};

  ppfs_periph_model u_model (.i2c_mode_i(i2c), .timer_out_o(tmo), .aux_clock_o(aux),
    .cmp_out_o(cmp), .ser_req_o(sreq), .ser_a_req_o(sareq), .map_out_o(mo),
    .map_own_o(mown), .map_dir_o(mdir));

  ppfs_port_pin_function_select dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .port_one_function_select_i(s1), .port_one_direction_bit_i(d1),
    .port_one_gpio_out_i(g1), .port_one_timer_out_i(tmo), .aux_clock_i(aux),
    .comparator_output_i(cmp), .port_two_function_select_i(s2),
    .port_two_direction_bit_i(d2), .port_two_gpio_out_i(g2),
    .port_three_function_select_i(s3), .port_three_direction_bit_i(d3),
    .port_three_gpio_out_i(g3), .serial_pin_req_i(sreq), .serial_a_clock_req_i(sareq),
    .serial_four_wire_i(fw), .port_four_function_select_i(s4),
    .port_four_direction_bit_i(d4), .port_four_gpio_out_i(g4),
    .port_four_mapping_value_i(mv), .mapped_out_i(mo), .mapped_dir_own_i(mown),
    .mapped_dir_i(mdir), .port_five_select_i(s5), .port_five_direction_bit_i(d5),
    .port_five_gpio_out_i(g5), .reference_output_enable_i(rfo),
    .hf_oscillator_bypass_i(byp), .converter_channel_select_i(ch), .p1_pad_i(pd1),
    .p2_pad_i(pd2), .p3_pad_i(pd3), .p4_pad_i(pd4), .p5_pad_i(pd5), .p1_pad_o(o1),
    .p2_pad_o(o2n), .p3_pad_o(o3n), .p4_pad_o(o4), .p5_pad_o(o5n), .timer_capture_o(cap),
    .serial_pin_in_o(sin), .serial_a_clock_in_o(sain), .serial_three_wire_o(tw),
    .mapped_in_o(mi), .port_one_pin_in_o(pin1), .ref_pos_out_en_o(rpos),
    .ext_ref_in_en_o(xref), .chan_to_pos_ref_o(cpos), .chan_to_neg_ref_o(cneg),
    .hf_crystal_input_en_o(xin), .hf_bypass_in_en_o(bin),
    .hf_crystal_output_en_o(xout), .hf_clock_in_o(hclk));

  // Pulls one pad field (2 out, 1 oe, 0 ie) out of up to eight pads
  function automatic logic [7:0] fld(input logic [23:0] v, input int k);
    for (int i = 0; i < 8; i++)
    begin
      fld[i] = v[3*i+k];
    end
  endfunction : fld

  // Compares one byte of result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits edges, then moves just past the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  // Prints the counts and the verdict
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Clock at 125 MHz
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Cuts a hang short
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == MAX_CYC)
    begin
      num_errors++;
      finish_test();
    end
  end

  // Main sequence
  initial
  begin
    {reset_n_i, s2, d2, g2, pd2, fw, rfo, byp, i2c} = '0;
    {s1, d1, g1, pd1, s4, d4, g4, pd4, mv} = '0;
    {s3, d3, g3, pd3, s5, d5, g5, pd5, ch} = '0;
    step(4);
    chk(fld(o1, 1) | fld(o4, 1) | fld(o3, 1) | fld(o5, 1) | fld(o2, 1), 8'h00);
    chk({tw, rpos, xref, cpos, cneg, xin, bin, xout}, 8'h00);
    reset_n_i = 1'b1;
    step(1);
    chk(fld(o1, 1) | fld(o4, 1) | fld(o3, 1) | fld(o5, 1) | fld(o2, 1), 8'h00);
    $display("Test reset done");
    // Port one: every pin meets two opposite select and direction pairs, all four across the pins
    {g1, pd1} = {8'h3c, 8'h96};
    for (int t = 0; t < 2; t++)
    begin
      s1 = t ? 8'h3c : 8'hc3;
      d1 = t ? 8'h5a : 8'ha5;
      step(3);
      chk(fld(o1, 1), d1);
      chk(fld(o1, 2) & d1, ((s1 & 8'he5) | (~s1 & g1)) & d1);
      chk(cap & s1 & ~d1, pd1 & s1 & ~d1);
      chk(pin1 & ~s1 & ~d1, pd1 & ~s1 & ~d1);
    end
    $display("Test port one done");
    // Serial pins: direction bits low, yet the peripheral drives
    {s2, d2, fw, pd2} = 4'hb;
    {s3, d3, pd3} = {5'h1f, 5'h00, 5'h13};
    step(3);
    chk(fld(o2, 1) & fld(o2, 2), 8'h01);
    chk({6'h00, sain, tw}, 8'h03);
    chk(fld(o3, 1), 8'h1f);
    chk(fld(o3, 2), 8'h0a);
    chk({3'h0, sin}, 8'h13);
    i2c = 1'b1;
    step(1);
    chk(fld(o3, 2), 8'h00);
    chk(fld(o3, 1), 8'h15);
    s2 = 1'b0;
    step(1);
    chk({7'h00, tw}, 8'h01);
    {fw, i2c} = 2'h0;
    step(1);
    chk({7'h00, tw}, 8'h00);
    $display("Test serial done");
    // Port four: pin0 at the limit 30, pin1 one past it
    {s4, d4, g4, pd4} = {8'hff, 8'haa, 8'hff, 8'h69};
    mv = {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h1f, 5'h1e};
    step(3);
    chk(fld(o4, 1), 8'ha3);
    chk(fld(o4, 2) & 8'ha3, 8'h22);
    chk(mi & 8'h5c, 8'h48);
    $display("Test port four done");
    // Port five: analog pins, references and the crystal pair
    {s5, d5, g5, pd5, rfo, ch} = {4'h3, 4'hf, 4'hf, 4'h4, 1'b1, 4'h8};
    step(1);
    chk(fld(o5, 1), 8'h0c);
    chk(fld(o5, 0) & 8'h03, 8'h00);
    chk({4'h0, rpos, xref, cpos, cneg}, 8'h0a);
    {rfo, ch} = {1'b0, 4'h9};
    step(1);
    chk({4'h0, rpos, xref, cpos, cneg}, 8'h05);
    s5 = 4'h4;
    step(1);
    chk({5'h00, xin, bin, xout}, 8'h05);
    chk(fld(o5, 1), 8'h03);
    chk(fld(o5, 0) & 8'h04, 8'h00);
    byp = 1'b1;
    step(3);
    chk({4'h0, xin, bin, xout, hclk}, 8'h05);
    chk(fld(o5, 1), 8'h0b);
    chk(fld(o5, 2) & 8'h08, 8'h08);
    chk(fld(o5, 0) & 8'h04, 8'h04);
    {s5, byp} = {4'h8, 1'b0};
    step(1);
    chk(fld(o5, 1), 8'h0f);
    chk({5'h00, xin, bin, xout}, 8'h00);
    $display("Test port five done");
    finish_test();
  end
endmodule : tb_top
